// ==== design/tac_buf2.sv ====
// Two-entry valid/ready buffer before the ring
module tac_buf2
  import tac_pkg::*;
#(
  parameter int W = 81
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  logic [W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         rdy_r, rdy_nxt;
  logic         push, pop;

  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = d0_r;
  assign in_ready_o  = rdy_r;

  always_comb begin
    push    = in_valid_i & rdy_r;
    pop     = out_valid_o & out_ready_i;
    d0_nxt  = d0_r;
    d1_nxt  = d1_r;
    if (pop) begin
      d0_nxt = d1_r;
    end
    if (push) begin
      if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
        d0_nxt = in_data_i;
      end else begin
        d1_nxt = in_data_i;
      end
    end
    cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    // Registered ready: low out of reset, then only a full buffer refuses
    rdy_nxt = (cnt_nxt != 2'h2);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      d0_r  <= '0;
      d1_r  <= '0;
      cnt_r <= 2'h0;
      rdy_r <= 1'b0;
    end else begin
      d0_r  <= d0_nxt;
      d1_r  <= d1_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

endmodule

// ==== design/tac_pkg.sv ====
// Shared constants, types and helpers of trace acquisition control
// Notes on behaviour
// RULE_01: Delayed stop captures programmed count, then halts.
// RULE_02: Per-event stop selects act only when enabled.
// RULE_03: Immediate and delayed stop armed independently.
// RULE_04: Four range channels, all inactive in free mode.
// RULE_05: Channel modes: off, point, range, event.
// RULE_06: Point mode: start address opens, stop closes.
// RULE_07: Point triggers match one exact address.
// RULE_08: Cyclic re-arms the sequence after stop.
// RULE_09: Cyclic point mode captures every region entry.
// RULE_10: Range mode stores only matching bus cycles.
// RULE_11: Event mode: start event opens, stop closes.
// RULE_12: Cyclic event mode alternates capture and pause.
// RULE_13: Records carry probes unless time stamping.
// RULE_14: Delay counter loads, counts captures, ignores retriggers.
// RULE_15: Trace buffer is a ring overwriting oldest.
// RULE_16: Free mode captures from run start.
// RULE_17: 32-bit time stamp wraps and keeps counting.
package tac_pkg;

  localparam int NEV   = 16;
  localparam int NCH   = 4;
  localparam int DEPTH = 64;
  localparam int PW    = 6;

  // Register offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STOP_SEL  = 8'h04;
  localparam logic [7:0] OFS_DSTOP_SEL = 8'h08;
  localparam logic [7:0] OFS_DCOUNT    = 8'h0C;
  localparam logic [7:0] OFS_CH_CFG    = 8'h10;
  localparam logic [7:0] OFS_CH_START  = 8'h20;
  localparam logic [7:0] OFS_CH_STOP   = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h40;
  localparam logic [7:0] OFS_TSTAMP    = 8'h44;
  localparam logic [7:0] OFS_REC_IDX   = 8'h48;
  localparam logic [7:0] OFS_REC_ADDR  = 8'h4C;
  localparam logic [7:0] OFS_REC_DATA  = 8'h50;
  localparam logic [7:0] OFS_REC_TAG   = 8'h54;

  // Control register fields
  localparam int CTRL_FREE_BIT  = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int CTRL_DSTOP_BIT = 2;
  localparam int CTRL_TS_LSB    = 4;

  // Status register fields
  localparam int ST_ACTIVE_BIT  = 8;
  localparam int ST_HALT_BIT    = 9;
  localparam int ST_DACT_BIT    = 10;
  localparam int ST_WRAP_BIT    = 11;
  localparam int ST_DCNT_LSB    = 16;

  // Reset values
  localparam logic [7:0]  CTRL_RST   = 8'h01;
  localparam logic [15:0] DCOUNT_RST = 16'h0001;

  // Channel modes
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_POINT = 2'h1;
  localparam logic [1:0] MODE_RANGE = 2'h2;
  localparam logic [1:0] MODE_EVENT = 2'h3;

  // Stamp resolutions in ns for selector 1..9; 0 is off
  localparam int CLK_PERIOD_NS = 25;
  localparam int TS_NSEL       = 9;
  localparam int TS_RES_NS [1:TS_NSEL] = '{125, 250, 500, 1000, 2000,
                                           4000, 8000, 16000, 100000};

  typedef enum logic [2:0] {
    ACQ_WAIT = 3'b001,
    ACQ_RUN  = 3'b010,
    ACQ_HALT = 3'b100
  } tac_acq_e;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_OPEN = 3'b010,
    CH_DONE = 3'b100
  } tac_ch_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic        rw;
  } tac_cyc_s;

  typedef struct packed {
    tac_cyc_s    cyc;
    logic [31:0] tag;
  } tac_rec_s;

  typedef struct packed {
    logic [3:0] stop_ev;
    logic [3:0] start_ev;
    logic [1:0] pad;
    logic       cyclic;
    logic       pad2;
    logic [1:0] mode;
  } tac_cfg_s;

  // Clock cycles per tick
  function automatic logic [11:0] ts_cycles(input logic [3:0] sel);
    ts_cycles = 12'h001;
    for (int i = 1; i <= TS_NSEL; i++) begin
      if (sel == 4'(i)) begin
        ts_cycles = 12'(TS_RES_NS[i] / CLK_PERIOD_NS);
      end
    end
  endfunction

  function automatic logic ev_pick(input logic [NEV-1:0] ev, input logic [3:0] idx);
    ev_pick = ev[idx];
  endfunction

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] base);
    reg_hit = (a[7:4] == base[7:4]);
  endfunction

endpackage

// ==== design/tac_top.sv ====
// Trace acquisition control: triggers, stops and ring store
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module tac_top
  import tac_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  // Target bus cycle stream and event matches
  input  wire logic            cyc_valid_i,
  input  wire tac_cyc_s        cyc_i,
  input  wire logic [NEV-1:0]  evt_i,
  output logic                 cyc_ready_o,
  // Probe inputs and execution state
  input  wire logic [3:0]      probe_i,
  input  wire logic [7:0]      interrupt_probe_inputs_i,
  input  wire logic            exec_run_i,
  // Register port
  input  wire logic [7:0]      addr_i,
  input  wire logic [31:0]     wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic [31:0]          rdata_o,
  // Status
  output logic                 acq_active_o,
  output logic                 acq_halted_o
);

  localparam int RW = $bits(tac_rec_s);

  logic [7:0]     ctrl_r, ctrl_nxt;
  logic [NEV-1:0] ssel_r, ssel_nxt;
  logic [NEV-1:0] dsel_r, dsel_nxt;
  logic [15:0]    dcount_r, dcount_nxt;
  logic [PW-1:0]  ridx_r, ridx_nxt;
  tac_cfg_s       cfg_r [NCH];
  tac_cfg_s       cfg_nxt [NCH];
  logic [31:0]    sa_r [NCH];
  logic [31:0]    sa_nxt [NCH];
  logic [31:0]    pa_r [NCH];
  logic [31:0]    pa_nxt [NCH];

  tac_acq_e       acq_r, acq_nxt;
  logic [15:0]    dcnt_r, dcnt_nxt;
  logic           dact_r, dact_nxt;
  logic           act_o_nxt, halt_o_nxt;
  logic           act_q, halt_q;

  tac_rec_s       mem [DEPTH];
  logic [PW-1:0]  wptr_r, wptr_nxt;
  logic           wrap_r, wrap_nxt;
  logic [31:0]    rdata_nxt;

  logic           free, acc, store, push, imm, dtrig, mem_rd, any_en;
  logic [NCH-1:0] ch_en, ch_qual;
  logic [31:0]    ts;
  tac_rec_s       rec, rec_rd;
  logic           b_valid, b_ready;
  logic [RW-1:0]  b_data;
  logic [1:0]     ch_sel;

  assign free   = ctrl_r[CTRL_FREE_BIT];
  assign acc    = (acq_r == ACQ_RUN) & cyc_valid_i & cyc_ready_o;
  assign any_en = |ch_en;
  assign ch_sel = addr_i[3:2];
  assign mem_rd = rd_i & (addr_i == OFS_REC_ADDR || addr_i == OFS_REC_DATA
                          || addr_i == OFS_REC_TAG);

  tac_tstamp u_ts (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .sel_i     (ctrl_r[CTRL_TS_LSB +: 4]),
    .ts_o      (ts)
  );

  // Stamp replaces probe fields [RULE_13]
  always_comb begin
    rec.cyc = cyc_i;
    if (ctrl_r[CTRL_TS_LSB +: 4] != 4'h0) begin
      rec.tag = ts;
    end else begin
      rec.tag = {20'h00000, interrupt_probe_inputs_i, probe_i};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tac_ch_e st_r, st_nxt;
      logic    hs, hp, q;

      always_comb begin
        // Dead in free mode or when off [RULE_04] [RULE_05]
        ch_en[g] = ~free & (cfg_r[g].mode != MODE_OFF);
        q        = 1'b0;
        st_nxt   = st_r;
        if (cfg_r[g].mode == MODE_POINT) begin
          // Exact single-address match [RULE_06] [RULE_07]
          hs = (cyc_i.addr == sa_r[g]);
          hp = (cyc_i.addr == pa_r[g]);
        end else begin
          // Event mode start/stop [RULE_11]
          hs = ev_pick(evt_i, cfg_r[g].start_ev);
          hp = ev_pick(evt_i, cfg_r[g].stop_ev);
        end
        if (!ch_en[g] || acq_r == ACQ_WAIT) begin
          st_nxt = CH_IDLE;
        end else if (cfg_r[g].mode == MODE_RANGE) begin
          // Keep only matching cycles [RULE_10]
          q = ev_pick(evt_i, cfg_r[g].start_ev);
        end else begin
          case (st_r)
            CH_IDLE: begin
              if (acc && hs) begin
                q      = 1'b1;
                st_nxt = CH_OPEN;
                if (hp) begin
                  st_nxt = cfg_r[g].cyclic ? CH_IDLE : CH_DONE;
                end
              end
            end
            CH_OPEN: begin
              q = 1'b1;
              if (acc && hp) begin
                // Cyclic re-arms [RULE_08] [RULE_09] [RULE_12]
                st_nxt = cfg_r[g].cyclic ? CH_IDLE : CH_DONE;
              end
            end
            CH_DONE: begin
              q = 1'b0;
            end
            default: begin
              st_nxt = CH_IDLE;
            end
          endcase
        end
        ch_qual[g] = q;
      end

      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          st_r <= CH_IDLE;
        end else begin
          st_r <= st_nxt;
        end
      end
    end
  endgenerate

  always_comb begin
    // No channel on: keep all [RULE_16]
    store    = free | ~any_en | (|ch_qual);
    push     = acc & store;
    // Selects act only when enabled [RULE_02] [RULE_03]
    imm      = ctrl_r[CTRL_STOP_BIT] & (|(evt_i & ssel_r));
    dtrig    = ctrl_r[CTRL_DSTOP_BIT] & (|(evt_i & dsel_r)) & ~dact_r;
    acq_nxt  = acq_r;
    dcnt_nxt = dcnt_r;
    dact_nxt = dact_r;
    case (acq_r)
      ACQ_WAIT: begin
        dact_nxt = 1'b0;
        if (exec_run_i) begin
          acq_nxt = ACQ_RUN; // [RULE_16]
        end
      end
      ACQ_RUN: begin
        if (!exec_run_i) begin
          acq_nxt = ACQ_WAIT;
        end else if (acc && imm) begin
          acq_nxt = ACQ_HALT; // [RULE_03]
        end else if (acc && dact_r && push) begin
          // Counts stored cycles after trigger [RULE_14] [RULE_01]
          dcnt_nxt = dcnt_r - 16'h0001;
          if (dcnt_r == 16'h0001) begin
            acq_nxt  = ACQ_HALT;
            dact_nxt = 1'b0;
          end
        end else if (acc && dtrig) begin
          dact_nxt = 1'b1; // [RULE_14]
          dcnt_nxt = dcount_r;
        end
      end
      ACQ_HALT: begin
        dact_nxt = 1'b0;
        if (!exec_run_i) begin
          acq_nxt = ACQ_WAIT;
        end
      end
      default: begin
        acq_nxt = ACQ_WAIT;
      end
    endcase
    act_o_nxt  = (acq_nxt == ACQ_RUN);
    halt_o_nxt = (acq_nxt == ACQ_HALT);
  end

  // Software record reads hold the memory port and stall the drain
  tac_buf2 #(.W(RW)) u_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_data_i   (rec),
    .in_ready_o  (cyc_ready_o),
    .out_valid_o (b_valid),
    .out_data_o  (b_data),
    .out_ready_i (b_ready)
  );

  assign b_ready = ~mem_rd;

  // Ring wraps over oldest [RULE_15]
  always_comb begin
    wptr_nxt = wptr_r;
    wrap_nxt = wrap_r;
    if (b_valid && b_ready) begin
      wptr_nxt = wptr_r + 6'h01;
      if (wptr_r == 6'(DEPTH - 1)) begin
        wrap_nxt = 1'b1;
      end
    end
  end

  always_comb begin
    ctrl_nxt   = ctrl_r;
    ssel_nxt   = ssel_r;
    dsel_nxt   = dsel_r;
    dcount_nxt = dcount_r;
    ridx_nxt   = ridx_r;
    cfg_nxt    = cfg_r;
    sa_nxt     = sa_r;
    pa_nxt     = pa_r;
    if (wr_i) begin
      if (addr_i == OFS_CTRL) begin
        ctrl_nxt = wdata_i[7:0];
      end
      if (addr_i == OFS_STOP_SEL) begin
        ssel_nxt = wdata_i[NEV-1:0];
      end
      if (addr_i == OFS_DSTOP_SEL) begin
        dsel_nxt = wdata_i[NEV-1:0];
      end
      if (addr_i == OFS_DCOUNT) begin
        // Zero is stored as one [RULE_01]
        dcount_nxt = (wdata_i[15:0] == 16'h0000) ? 16'h0001 : wdata_i[15:0];
      end
      if (addr_i == OFS_REC_IDX) begin
        ridx_nxt = wdata_i[PW-1:0];
      end
      if (reg_hit(addr_i, OFS_CH_CFG)) begin
        cfg_nxt[ch_sel] = wdata_i[13:0];
      end
      if (reg_hit(addr_i, OFS_CH_START)) begin
        sa_nxt[ch_sel] = wdata_i;
      end
      if (reg_hit(addr_i, OFS_CH_STOP)) begin
        pa_nxt[ch_sel] = wdata_i;
      end
    end
  end

  // Register reads, answered one cycle later
  always_comb begin
    rec_rd    = mem[ridx_r];
    rdata_nxt = 32'h0000_0000;
    if (rd_i) begin
      if (addr_i == OFS_CTRL) begin
        rdata_nxt = {24'h000000, ctrl_r};
      end else if (addr_i == OFS_STOP_SEL) begin
        rdata_nxt = {16'h0000, ssel_r};
      end else if (addr_i == OFS_DSTOP_SEL) begin
        rdata_nxt = {16'h0000, dsel_r};
      end else if (addr_i == OFS_DCOUNT) begin
        rdata_nxt = {16'h0000, dcount_r};
      end else if (reg_hit(addr_i, OFS_CH_CFG)) begin
        rdata_nxt = {18'h00000, cfg_r[ch_sel]};
      end else if (reg_hit(addr_i, OFS_CH_START)) begin
        rdata_nxt = sa_r[ch_sel];
      end else if (reg_hit(addr_i, OFS_CH_STOP)) begin
        rdata_nxt = pa_r[ch_sel];
      end else if (addr_i == OFS_STATUS) begin
        rdata_nxt = {dcnt_r, 4'h0, wrap_r, dact_r, halt_q, act_q, 2'h0, wptr_r};
      end else if (addr_i == OFS_TSTAMP) begin
        rdata_nxt = ts;
      end else if (addr_i == OFS_REC_IDX) begin
        rdata_nxt = {26'h0000000, ridx_r};
      end else if (addr_i == OFS_REC_ADDR) begin
        rdata_nxt = rec_rd.cyc.addr;
      end else if (addr_i == OFS_REC_DATA) begin
        rdata_nxt = {15'h0000, rec_rd.cyc.rw, rec_rd.cyc.data};
      end else if (addr_i == OFS_REC_TAG) begin
        rdata_nxt = rec_rd.tag;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (b_valid && b_ready) begin
      mem[wptr_r] <= b_data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r   <= CTRL_RST;
      ssel_r   <= '0;
      dsel_r   <= '0;
      dcount_r <= DCOUNT_RST;
      ridx_r   <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_r[i] <= '0;
        sa_r[i]  <= '0;
        pa_r[i]  <= '0;
      end
      acq_r    <= ACQ_WAIT;
      dcnt_r   <= 16'h0000;
      dact_r   <= 1'b0;
      act_q    <= 1'b0;
      halt_q   <= 1'b0;
      wptr_r   <= '0;
      wrap_r   <= 1'b0;
      rdata_o  <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      ssel_r   <= ssel_nxt;
      dsel_r   <= dsel_nxt;
      dcount_r <= dcount_nxt;
      ridx_r   <= ridx_nxt;
      cfg_r    <= cfg_nxt;
      sa_r     <= sa_nxt;
      pa_r     <= pa_nxt;
      acq_r    <= acq_nxt;
      dcnt_r   <= dcnt_nxt;
      dact_r   <= dact_nxt;
      act_q    <= act_o_nxt;
      halt_q   <= halt_o_nxt;
      wptr_r   <= wptr_nxt;
      wrap_r   <= wrap_nxt;
      rdata_o  <= rdata_nxt;
    end
  end

  assign acq_active_o = act_q;
  assign acq_halted_o = halt_q;

endmodule

// ==== design/tac_tstamp.sv ====
// 32-bit time stamp with selectable tick
module tac_tstamp
  import tac_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Control and value
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      ts_o
);

  logic [11:0] pre_r, pre_nxt;
  logic [31:0] ts_r, ts_nxt;
  logic        on;

  assign ts_o = ts_r;

  always_comb begin
    on      = (sel_i != 4'h0) && (sel_i <= 4'(TS_NSEL));
    pre_nxt = pre_r;
    ts_nxt  = ts_r;
    if (!on) begin
      pre_nxt = 12'h000;
    end else if (pre_r >= ts_cycles(sel_i) - 12'h001) begin
      pre_nxt = 12'h000;
      // Wraps to zero on overflow [RULE_17]
      ts_nxt  = ts_r + 32'h0000_0001;
    end else begin
      pre_nxt = pre_r + 12'h001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r <= 12'h000;
      ts_r  <= 32'h0000_0000;
    end else begin
      pre_r <= pre_nxt;
      ts_r  <= ts_nxt;
    end
  end

endmodule

// ==== test/tac_target_model.sv ====
// Model of the emulated target: bus cycle stream, event matches and probe lines
module tac_target_model
  import tac_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      rst_i,
  // Bus cycle stream
  input  wire logic      cyc_ready_i,
  output logic           cyc_valid_o,
  output tac_cyc_s       cyc_o,
  output logic [NEV-1:0] evt_o,
  // Probe lines
  output logic [3:0]     probe_o,
  output logic [7:0]     irq_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cyc_valid_o = 1'b0;
    cyc_o       = '0;
    evt_o       = '0;
    probe_o     = 4'h0;
    irq_o       = 8'h00;
  end

  // Probes follow the address, so tags are predictable
  task automatic send(input logic [31:0] a, input logic [NEV-1:0] e);
    cyc_valid_o <= 1'b1;
    cyc_o       <= '{addr: a, data: a[15:0] ^ 16'h5A5A, rw: a[0]};
    evt_o       <= e;
    probe_o     <= a[3:0];
    irq_o       <= a[11:4];
    @(posedge ref_clk_i);
    // A stalled cycle is held for at most 64 further clocks
    for (int n = 0; n < 64 && !cyc_ready_i; n++) @(posedge ref_clk_i);
  endtask

  // Released cycle and event lines show the inverse of the last value; probes hold
  task automatic idle(input int n);
    cyc_valid_o <= 1'b0;
    cyc_o       <= ~cyc_o;
    evt_o       <= ~evt_o;
    repeat (n) @(posedge ref_clk_i);
  endtask
endmodule

// ==== test/tac_top_assertions.sv ====
// Port-level checker for trace acquisition control
module tac_top_assertions
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic           ref_clk_i,
  input wire logic           rst_i,
  // Stream, execution and register writes
  input wire logic           cyc_valid_i,
  input wire logic [NEV-1:0] evt_i,
  input wire logic           cyc_ready_o,
  input wire logic           exec_run_i,
  input wire logic [7:0]     addr_i,
  input wire logic [31:0]    wdata_i,
  input wire logic           wr_i,
  // Status
  input wire logic           acq_active_o,
  input wire logic           acq_halted_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic           free_r;
  logic           sen_r;
  logic           den_r;
  logic           dbusy_r;
  logic [NEV-1:0] ssel_r;
  logic [NEV-1:0] dsel_r;
  logic [15:0]    dcnt_r;
  logic [15:0]    dleft_r;
  logic           acc;
  logic           s_hit;
  logic           d_hit;

  assign acc   = cyc_valid_i && cyc_ready_o && acq_active_o;
  assign s_hit = acc && |(evt_i & ssel_r);
  assign d_hit = acc && |(evt_i & dsel_r);

  // Stop-control shadow; delay tracked in free mode only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      free_r  <= 1'b1;
      sen_r   <= 1'b0;
      den_r   <= 1'b0;
      ssel_r  <= '0;
      dsel_r  <= '0;
      dcnt_r  <= 16'h0001;
      dbusy_r <= 1'b0;
      dleft_r <= 16'h0000;
    end else begin
      if (wr_i && addr_i == OFS_CTRL) begin
        free_r <= wdata_i[CTRL_FREE_BIT];
        sen_r  <= wdata_i[CTRL_STOP_BIT];
        den_r  <= wdata_i[CTRL_DSTOP_BIT];
      end
      if (wr_i && addr_i == OFS_STOP_SEL) begin
        ssel_r <= wdata_i[NEV-1:0];
      end
      if (wr_i && addr_i == OFS_DSTOP_SEL) begin
        dsel_r <= wdata_i[NEV-1:0];
      end
      if (wr_i && addr_i == OFS_DCOUNT) begin
        dcnt_r <= (wdata_i[15:0] == 16'h0000) ? 16'h0001 : wdata_i[15:0];
      end
      if (!exec_run_i) begin
        dbusy_r <= 1'b0;
      end else if (dbusy_r && acc) begin
        dleft_r <= dleft_r - 16'h0001;
        dbusy_r <= (dleft_r != 16'h0001);
      end else if (den_r && free_r && d_hit && !dbusy_r && !acq_halted_o) begin
        dbusy_r <= 1'b1;
        dleft_r <= dcnt_r;
      end
    end
  end

  AST_STOP_NOW: assert property (sen_r && s_hit && !acq_halted_o |-> ##[1:2] acq_halted_o)
    else $error("no halt on stop event");
  AST_HALT_CAUSE: assert property ($rose(acq_halted_o) |-> sen_r || den_r)
    else $error("halt with no stop enabled");
  AST_DSTOP_HALT: assert property (dbusy_r && acc && dleft_r == 16'h0001 |-> ##[1:2] acq_halted_o)
    else $error("no halt after delay count");
  AST_DSTOP_HOLD: assert property (dbusy_r && !sen_r && dleft_r > 16'h0001 |=> !acq_halted_o)
    else $error("delayed stop halted early");
  AST_BOTH_ARMED: assert property (den_r && dbusy_r && sen_r && s_hit |-> ##[1:2] acq_halted_o)
    else $error("stop ignored during delay");
  AST_HALT_QUIET: assert property (acq_halted_o |-> !acq_active_o)
    else $error("active while halted");
  AST_RUN_NEEDS_EXEC: assert property (!exec_run_i |=> !acq_active_o)
    else $error("active while not running");
  AST_FREE_START: assert property ($rose(exec_run_i) && free_r && !acq_halted_o |=> acq_active_o)
    else $error("free mode did not start");

  COV_STOP: cover property (sen_r && s_hit);
  COV_DSTOP: cover property (dbusy_r && acc && dleft_r == 16'h0001);
  COV_FREE: cover property ($rose(exec_run_i) && free_r);
endmodule

bind tac_top tac_top_assertions chk_u (
  .ref_clk_i    (ref_clk_i),
  .rst_i        (rst_i),
  .cyc_valid_i  (cyc_valid_i),
  .evt_i        (evt_i),
  .cyc_ready_o  (cyc_ready_o),
  .exec_run_i   (exec_run_i),
  .addr_i       (addr_i),
  .wdata_i      (wdata_i),
  .wr_i         (wr_i),
  .acq_active_o (acq_active_o),
  .acq_halted_o (acq_halted_o)
);

// ==== test/tac_top_tb.sv ====
// Directed bench for the trace acquisition control block
module tac_top_tb
  import tac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic           ref_clk_i;
  logic           rst_i;
  logic           cyc_valid_i;
  tac_cyc_s       cyc_i;
  logic [NEV-1:0] evt_i;
  logic           cyc_ready_o;
  logic [3:0]     probe_i;
  logic [7:0]     irq_i;
  logic           exec_run_i;
  logic [7:0]     addr_i;
  logic [31:0]    wdata_i;
  logic           wr_i;
  logic           rd_i;
  logic [31:0]    rdata_o;
  logic           acq_active_o;
  logic           acq_halted_o;
  int             fail_count;
  int             compares;

  tac_top dut_u (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .cyc_valid_i (cyc_valid_i), .cyc_i (cyc_i),
    .evt_i (evt_i), .cyc_ready_o (cyc_ready_o), .probe_i (probe_i),
    .interrupt_probe_inputs_i (irq_i), .exec_run_i (exec_run_i), .addr_i (addr_i),
    .wdata_i (wdata_i), .wr_i (wr_i), .rd_i (rd_i), .rdata_o (rdata_o),
    .acq_active_o (acq_active_o), .acq_halted_o (acq_halted_o)
  );

  tac_target_model tgt_u (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .cyc_ready_i (cyc_ready_o),
    .cyc_valid_o (cyc_valid_i), .cyc_o (cyc_i), .evt_o (evt_i),
    .probe_o (probe_i), .irq_o (irq_i)
  );

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Data stands in the cycle after the strobe; look mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    compares++;
    if ((rdata_o & m) !== e) begin
      fail_count++;
      $display("mismatch %0t: reg %h got %h exp %h", $time, a, rdata_o, e);
    end
    @(posedge ref_clk_i);
  endtask

  function automatic logic [31:0] ccfg(logic [1:0] m, logic c, logic [3:0] s, logic [3:0] p);
    tac_cfg_s cfg;
    cfg = '{stop_ev: p, start_ev: s, pad: 2'h0, cyclic: c, pad2: 1'b0, mode: m};
    return 32'(cfg);
  endfunction

  // Reset per test rewinds the ring pointer and clears channels
  task automatic start(input logic [31:0] ctrl);
    exec_run_i <= 1'b0;
    rst_i      <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    wr(OFS_CTRL, ctrl);
  endtask

  task automatic feed(input logic [31:0] a[$], input logic [15:0] e[$], input logic [7:0] cfo,
                      input logic [31:0] cfg);
    wr(cfo, cfg);
    exec_run_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    foreach (a[i]) tgt_u.send(a[i], (i < e.size()) ? e[i] : 16'h0000);
    tgt_u.idle(6);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge ref_clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    ref_clk_i  = 1'b0;
    rst_i      = 1'b1;
    exec_run_i = 1'b0;
    addr_i     = 8'h00;
    wdata_i    = 32'h0000_0000;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    fail_count = 0;
    compares   = 0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd_chk(OFS_CTRL, 32'h0000_00FF, 32'h0000_0001);
    rd_chk(OFS_DCOUNT, 32'h0000_FFFF, 32'h0000_0001);
    wr(8'hF0, 32'hFFFF_FFFF);
    rd_chk(8'hF0, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_DCOUNT, 32'h0000_FFFF);
    rd_chk(OFS_DCOUNT, 32'h0000_FFFF, 32'h0000_FFFF);
    wr(OFS_DCOUNT, 32'h0000_0000);
    rd_chk(OFS_DCOUNT, 32'h0000_FFFF, 32'h0000_0001);
    $display("regs done");
    start(32'h0000_0003);
    wr(OFS_STOP_SEL, 32'h0000_0008);
    feed('{32'h101, 32'h102, 32'h103, 32'h104, 32'h105}, '{16'h0, 16'h20, 16'h0, 16'h8},
         OFS_DSTOP_SEL, 32'h0000_0020);
    rd_chk(OFS_STATUS, 32'h0000_033F, 32'h0000_0204);
    wr(OFS_REC_IDX, 32'h0000_0003);
    rd_chk(OFS_REC_ADDR, 32'hFFFF_FFFF, 32'h0000_0104);
    rd_chk(OFS_REC_TAG, 32'h0000_0FFF, 32'h0000_0104);
    $display("stop done");
    for (int k = 1; k <= 3; k += 2) begin
      start(32'h0000_0005);
      wr(OFS_DCOUNT, 32'(k));
      feed('{32'h201, 32'h202, 32'h203, 32'h204, 32'h205, 32'h206, 32'h207},
           '{16'h0, 16'h0, 16'h4, 16'h4}, OFS_DSTOP_SEL, 32'h0000_0004);
      rd_chk(OFS_STATUS, 32'h0000_033F, 32'h0000_0200 + 32'(3 + k));
    end
    start(32'h0000_0007);
    wr(OFS_STOP_SEL, 32'h0000_0008);
    wr(OFS_DCOUNT, 32'h0000_000A);
    feed('{32'h301, 32'h302, 32'h303, 32'h304}, '{16'h4, 16'h0, 16'h8},
         OFS_DSTOP_SEL, 32'h0000_0004);
    rd_chk(OFS_STATUS, 32'h0000_033F, 32'h0000_0203);
    $display("dstop done");
    for (int ch = 0; ch < NCH; ch++) begin
      for (int cy = 0; cy < 2; cy++) begin
        start(32'h0000_0000);
        wr(OFS_CH_START + 8'(4 * ch), 32'h0000_0200);
        wr(OFS_CH_STOP + 8'(4 * ch), 32'h0000_0300);
        feed('{32'h100, 32'h201, 32'h200, 32'h110, 32'h300, 32'h120, 32'h200, 32'h130,
               32'h300}, '{16'h0}, OFS_CH_CFG + 8'(4 * ch),
             ccfg(MODE_POINT, cy[0], 4'h0, 4'h0));
        rd_chk(OFS_STATUS, 32'h0000_003F, 32'(3 + 3 * cy));
      end
    end
    $display("point done");
    for (int cy = 0; cy < 2; cy++) begin
      start(32'h0000_0000);
      feed('{32'h401, 32'h402, 32'h403, 32'h404, 32'h405, 32'h406, 32'h407},
           '{16'h0, 16'h2, 16'h0, 16'h4, 16'h0, 16'h2, 16'h4}, OFS_CH_CFG + 8'h08,
           ccfg(MODE_EVENT, cy[0], 4'h1, 4'h2));
      rd_chk(OFS_STATUS, 32'h0000_003F, 32'(3 + 2 * cy));
    end
    $display("event done");
    for (int i = 0; i < 3; i++) begin
      start((i == 2) ? 32'h0000_0001 : 32'h0000_0000);
      feed('{32'h601, 32'h602, 32'h603, 32'h604, 32'h605, 32'h606},
           '{16'h0, 16'h10, 16'h0, 16'h10, 16'h12}, OFS_CH_CFG + 8'h04,
           ccfg((i == 1) ? MODE_OFF : MODE_RANGE, 1'b0, 4'h4, 4'h0));
      rd_chk(OFS_STATUS, 32'h0000_003F, (i == 0) ? 32'h0000_0003 : 32'h0000_0006);
    end
    $display("range done");
    start(32'h0000_0001);
    exec_run_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 66; i++) tgt_u.send(32'h0000_0500 + 32'(i), 16'h0000);
    tgt_u.idle(6);
    rd_chk(OFS_STATUS, 32'h0000_0B3F, 32'h0000_0902);
    wr(OFS_REC_IDX, 32'h0000_0000);
    rd_chk(OFS_REC_ADDR, 32'hFFFF_FFFF, 32'h0000_0540);
    $display("ring done");
    test_done();
  end
endmodule
